/* File: pkg/lfrsf_defines.svh */
`ifndef LFRSF_DEFINES_SVH
`define LFRSF_DEFINES_SVH

// register byte addresses on the bus
`define LFRSF_ADDR_CTRL          8'h20
`define LFRSF_ADDR_STATUS        8'h24
`define LFRSF_ADDR_DATA          8'h28

// status register bit positions
`define LFRSF_ST_BYTE_READY      7
`define LFRSF_ST_RX_ERROR        6
`define LFRSF_ST_CARRIER         5
`define LFRSF_ST_ID_MATCH        4
`define LFRSF_ST_OVERRUN         3
`define LFRSF_ST_EOM             2
`define LFRSF_ST_SNIFF           1
`define LFRSF_ST_ACK             0

// reset values
`define LFRSF_STATUS_RESET       8'h02
`define LFRSF_CTRL_RESET         16'h0008

// sync search limit codes and their nominal times in ms
`define LFRSF_LIMIT_NONE         2'b00
`define LFRSF_LIMIT_SHORT        2'b01
`define LFRSF_LIMIT_MID          2'b10
`define LFRSF_LIMIT_LONG         2'b11
`define LFRSF_SYNC_SHORT_MS      8
`define LFRSF_SYNC_MID_MS        24
`define LFRSF_SYNC_LONG_MS       48

// axi responses
`define LFRSF_RESP_OKAY          2'b00
`define LFRSF_RESP_SLVERR        2'b10

`endif

/* File: pkg/lfrsf_pkg.sv */
package lfrsf_pkg;

  // control register layout, bit 15 down to bit 0
  typedef struct packed {
    logic [3:0] validation_count_setting; // 15:12
    logic       spare;                    // 11
    logic       register_page_select;     // 10
    logic       toggle_mode;              // 9
    logic       carrier_mode_select;      // 8
    logic       byte_ready_irq_enable;    // 7
    logic       receive_error_irq_enable; // 6
    logic       carrier_detect_irq_enable;// 5
    logic       id_match_irq_enable;      // 4
    logic       decoder_enable;           // 3
    logic       spare2;                   // 2
    logic [1:0] sync_search_limit;        // 1:0
  } lfrsf_ctrl_s;

  // strobes and byte from the detector and decoder
  typedef struct packed {
    logic       byte_done;
    logic       bit_error;
    logic       carrier_valid;
    logic       carrier_lost;
    logic       id_match;
    logic       eom_error;
    logic       sync_found;
    logic       search_start;
    logic [7:0] rx_byte;
  } lfrsf_evt_s;

  typedef enum logic [1:0] {
    TMO_IDLE,
    TMO_SEARCH,
    TMO_EXPIRED
  } lfrsf_tmo_e;

endpackage : lfrsf_pkg

/* File: src/lfrsf_top.sv */
// Summary of operation
// R1 - two-bit sync limit picks none, 8, 24 or 48 ms search time in data mode
// R2 - no sync within the search time switches the receiver off, timed by oscillator
// R3 - reset clears the sync limit field so search runs without timeout
// R4 - complete byte sets byte ready; interrupt while flag and its enable are set
// R5 - reading the received byte register, acknowledge or reset clears byte ready
// R6 - data mode bit-time error sets receive error flag, interrupts when enabled
// R7 - carrier mode holds receive error, overrun and end-of-message flags clear
// R8 - carrier mode sets carrier flag after configured consecutive validations
// R9 - toggle mode bypasses the validation count for the carrier flag
// R10 - data mode id match sets id flag, interrupts when its enable is set
// R11 - new byte before previous was read sets overrun, no own interrupt
// R12 - stored byte with end-of-message coding error sets eom flag, no interrupt
// R13 - low power sniff bit trades current for slower transition; reset sets it
// R14 - writing one to acknowledge clears all six event flags
// R15 - acknowledge self-clears at next bus clock edge and always reads zero
// R16 - writing zero to acknowledge does nothing; reset does not touch it
// R17 - reset clears every event flag
// R18 - status reachable only with page select clear; otherwise address maps elsewhere
// R19 - carrier interrupt enable ignored in data mode unless decoder is disabled
// R20 - every new byte overwrites the received byte register
// R21 - a flag set in the same cycle as acknowledge wins over the clear
`timescale 1ns/1ps
`include "lfrsf_defines.svh"

module lfrsf_top #(
  parameter int unsigned ADDR_W           = 8, // axi address width
  parameter int unsigned OSC_TICKS_PER_MS = 1  // oscillator periods per millisecond
) (
  input  wire logic                     CLOCK,          // bus clock, 10 MHz
  input  wire logic                     RSTN,           // async reset, active low
  input  wire logic [ADDR_W-1:0]        S_AXI_AWADDR,   // write address
  input  wire logic                     S_AXI_AWVALID,  // write address valid
  output logic                          S_AXI_AWREADY,  // write address ready
  input  wire logic [31:0]              S_AXI_WDATA,    // write data
  input  wire logic [3:0]               S_AXI_WSTRB,    // write byte strobes
  input  wire logic                     S_AXI_WVALID,   // write data valid
  output logic                          S_AXI_WREADY,   // write data ready
  output logic [1:0]                    S_AXI_BRESP,    // write response
  output logic                          S_AXI_BVALID,   // write response valid
  input  wire logic                     S_AXI_BREADY,   // write response ready
  input  wire logic [ADDR_W-1:0]        S_AXI_ARADDR,   // read address
  input  wire logic                     S_AXI_ARVALID,  // read address valid
  output logic                          S_AXI_ARREADY,  // read address ready
  output logic [31:0]                   S_AXI_RDATA,    // read data
  output logic [1:0]                    S_AXI_RRESP,    // read response
  output logic                          S_AXI_RVALID,   // read data valid
  input  wire logic                     S_AXI_RREADY,   // read data ready
  input  wire lfrsf_pkg::lfrsf_evt_s    LF_EVENTS,      // detector strobes and byte
  input  wire logic                     LF_OSC_CLK,     // receiver oscillator, sampled
  output logic                          RX_SHUTDOWN,    // receiver off after timeout
  output logic                          LOW_POWER_SNIFF,// sniff current mode
  output logic                          LF_IRQ          // interrupt request, high
);
  import lfrsf_pkg::*;

  localparam int unsigned TICK_W = 16;
  localparam logic [TICK_W-1:0] SHORT_TICKS = TICK_W'(`LFRSF_SYNC_SHORT_MS * OSC_TICKS_PER_MS);
  localparam logic [TICK_W-1:0] MID_TICKS   = TICK_W'(`LFRSF_SYNC_MID_MS * OSC_TICKS_PER_MS);
  localparam logic [TICK_W-1:0] LONG_TICKS  = TICK_W'(`LFRSF_SYNC_LONG_MS * OSC_TICKS_PER_MS);
  // status reset image; only the sniff bit is stored here
  localparam logic [7:0]        STATUS_RST  = `LFRSF_STATUS_RESET;

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // input synchroniser; the byte is held stable by the decoder around its strobe
  lfrsf_evt_s evt_meta_reg;
  lfrsf_evt_s evt_sync_reg;
  lfrsf_evt_s evt_prev_reg;
  logic       osc_meta_reg;
  logic       osc_sync_reg;
  logic       osc_prev_reg;
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      evt_meta_reg <= '0;
      evt_sync_reg <= '0;
      evt_prev_reg <= '0;
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      evt_meta_reg <= LF_EVENTS;
      evt_sync_reg <= evt_meta_reg;
      evt_prev_reg <= evt_sync_reg;
      osc_meta_reg <= LF_OSC_CLK;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
    end
  end

  // one-cycle pulses on rising strobe edges
  logic ev_byte, ev_err, ev_valid, ev_lost, ev_id, ev_eom, ev_sync, ev_start, osc_tick;
  assign ev_byte  = evt_sync_reg.byte_done     & ~evt_prev_reg.byte_done;
  assign ev_err   = evt_sync_reg.bit_error     & ~evt_prev_reg.bit_error;
  assign ev_valid = evt_sync_reg.carrier_valid & ~evt_prev_reg.carrier_valid;
  assign ev_lost  = evt_sync_reg.carrier_lost  & ~evt_prev_reg.carrier_lost;
  assign ev_id    = evt_sync_reg.id_match      & ~evt_prev_reg.id_match;
  assign ev_eom   = evt_sync_reg.eom_error     & ~evt_prev_reg.eom_error;
  assign ev_sync  = evt_sync_reg.sync_found    & ~evt_prev_reg.sync_found;
  assign ev_start = evt_sync_reg.search_start  & ~evt_prev_reg.search_start;
  assign osc_tick = osc_sync_reg & ~osc_prev_reg;

  // axi write channel state
  logic              aw_held_reg, aw_held_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic              w_held_reg, w_held_next;
  logic [31:0]       w_data_reg, w_data_next;
  logic [3:0]        w_strb_reg, w_strb_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              do_write;
  logic              wr_ctrl, wr_status;

  // control, data and status storage
  lfrsf_ctrl_s ctrl_reg, ctrl_next;
  logic [7:0]  rx_data_reg, rx_data_next;
  logic        dr_reg, dr_next;
  logic        er_reg, er_next;
  logic        cd_reg, cd_next;
  logic        id_reg, id_next;
  logic        ov_reg, ov_next;
  logic        eom_reg, eom_next;
  logic        sniff_reg, sniff_next;
  logic        ack_reg, ack_next;
  logic [3:0]  val_cnt_reg, val_cnt_next;
  logic        irq_reg, irq_next;

  // axi read channel state
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic        rd_take;
  logic        rd_data_clr;

  // timeout state
  lfrsf_tmo_e        tmo_state_reg, tmo_state_next;
  logic [TICK_W-1:0] tmo_cnt_reg, tmo_cnt_next;
  logic              shutdown_reg, shutdown_next;
  logic [TICK_W-1:0] limit_ticks;

  // address and data must both be held before the write lands
  assign S_AXI_AWREADY = ~aw_held_reg & ~bvalid_reg;
  assign S_AXI_WREADY  = ~w_held_reg & ~bvalid_reg;
  assign do_write      = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_ctrl       = do_write & (aw_addr_reg[7:0] == `LFRSF_ADDR_CTRL);
  assign wr_status     = do_write & (aw_addr_reg[7:0] == `LFRSF_ADDR_STATUS)
                         & ~ctrl_reg.register_page_select; // R18

  // write channel next state
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next  = w_held_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_next = 1'b1;
      aw_addr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_next = 1'b1;
      w_data_next = S_AXI_WDATA;
      w_strb_next = S_AXI_WSTRB;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      unique case (aw_addr_reg[7:0])
        `LFRSF_ADDR_CTRL, `LFRSF_ADDR_STATUS, `LFRSF_ADDR_DATA: bresp_next = `LFRSF_RESP_OKAY;
        default: bresp_next = `LFRSF_RESP_SLVERR;
      endcase
    end else if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `LFRSF_RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg  <= w_held_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP  = bresp_reg;

  // read channel: one read in flight, answered one edge after the address
  assign S_AXI_ARREADY = ~rvalid_reg;
  assign rd_take       = S_AXI_ARVALID & ~rvalid_reg;
  assign rd_data_clr   = rd_take & (S_AXI_ARADDR[7:0] == `LFRSF_ADDR_DATA);

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (rd_take) begin
      rvalid_next = 1'b1;
      rresp_next  = `LFRSF_RESP_OKAY;
      unique case (S_AXI_ARADDR[7:0])
        `LFRSF_ADDR_CTRL: rdata_next = {16'h0000, ctrl_reg};
        `LFRSF_ADDR_STATUS: begin
          // page set maps this address to a register outside this block
          if (ctrl_reg.register_page_select) begin // R18
            rdata_next = 32'h0000_0000;
          end else begin
            rdata_next = {24'h00_0000, dr_reg, er_reg, cd_reg, id_reg,
                          ov_reg, eom_reg, sniff_reg, 1'b0}; // R15
          end
        end
        `LFRSF_ADDR_DATA: rdata_next = {24'h00_0000, rx_data_reg};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = `LFRSF_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= `LFRSF_RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA  = rdata_reg;
  assign S_AXI_RRESP  = rresp_reg;

  // flag, control and data next values; every set term beats the ack clear
  logic data_mode, dec_on, byte_ev, cd_hit;
  always_comb begin
    data_mode    = ~ctrl_reg.carrier_mode_select;
    dec_on       = ctrl_reg.decoder_enable;
    byte_ev      = ev_byte & data_mode & dec_on;
    ctrl_next    = ctrl_reg;
    sniff_next   = sniff_reg;
    ack_next     = 1'b0; // R15
    rx_data_next = rx_data_reg;
    val_cnt_next = val_cnt_reg;
    cd_hit       = 1'b0;
    if (wr_ctrl) begin
      if (w_strb_reg[0]) ctrl_next[7:0] = w_data_reg[7:0];
      if (w_strb_reg[1]) ctrl_next[15:8] = w_data_reg[15:8];
    end
    if (wr_status && w_strb_reg[0]) begin
      sniff_next = w_data_reg[`LFRSF_ST_SNIFF]; // R13
      ack_next   = w_data_reg[`LFRSF_ST_ACK]; // R16
    end
    if (byte_ev) rx_data_next = evt_sync_reg.rx_byte; // R20
    // consecutive validation count, idle in toggle mode
    if (ctrl_reg.toggle_mode || data_mode || ev_lost) begin // R9
      val_cnt_next = 4'h0;
    end else if (ev_valid) begin
      if (val_cnt_reg >= ctrl_reg.validation_count_setting) begin // R8
        cd_hit       = 1'b1;
        val_cnt_next = 4'h0;
      end else begin
        val_cnt_next = val_cnt_reg + 4'h1;
      end
    end
    if (!data_mode && ctrl_reg.toggle_mode && ev_valid) cd_hit = 1'b1; // R9
    // ack clears the six flags one edge after the write; sets still win
    dr_next  = byte_ev | (dr_reg & ~ack_reg & ~rd_data_clr); // R4 R5 R14 R21
    ov_next  = (byte_ev & dr_reg & ~rd_data_clr) | (ov_reg & ~ack_reg); // R11 R21
    eom_next = (byte_ev & ev_eom) | (eom_reg & ~ack_reg); // R12
    er_next  = (ev_err & data_mode & dec_on) | (er_reg & ~ack_reg); // R6 R14
    id_next  = (ev_id & data_mode & dec_on) | (id_reg & ~ack_reg); // R10 R14
    cd_next  = cd_hit | (cd_reg & ~ack_reg); // R8 R14
    if (!data_mode) begin // R7
      er_next  = 1'b0;
      ov_next  = 1'b0;
      eom_next = 1'b0;
    end
    // carrier enable only counts in carrier mode or with decoder off
    irq_next = (dr_reg & ctrl_reg.byte_ready_irq_enable) // R4
             | (er_reg & ctrl_reg.receive_error_irq_enable) // R6
             | (id_reg & ctrl_reg.id_match_irq_enable) // R10
             | (cd_reg & ctrl_reg.carrier_detect_irq_enable & (~data_mode | ~dec_on)); // R19
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg    <= `LFRSF_CTRL_RESET; // R3
      rx_data_reg <= 8'h00;
      dr_reg      <= 1'b0; // R17
      er_reg      <= 1'b0;
      cd_reg      <= 1'b0;
      id_reg      <= 1'b0;
      ov_reg      <= 1'b0;
      eom_reg     <= 1'b0;
      sniff_reg   <= STATUS_RST[`LFRSF_ST_SNIFF]; // R13
      val_cnt_reg <= 4'h0;
      irq_reg     <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      rx_data_reg <= rx_data_next;
      dr_reg      <= dr_next;
      er_reg      <= er_next;
      cd_reg      <= cd_next;
      id_reg      <= id_next;
      ov_reg      <= ov_next;
      eom_reg     <= eom_next;
      sniff_reg   <= sniff_next;
      val_cnt_reg <= val_cnt_next;
      irq_reg     <= irq_next;
    end
  end

  // ack holds zero outside a write, so reset leaves it as it always reads
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next; // R15
    end
  end

  // search time per limit code, counted in oscillator periods
  always_comb begin
    unique case (ctrl_reg.sync_search_limit) // R1
      `LFRSF_LIMIT_SHORT: limit_ticks = SHORT_TICKS;
      `LFRSF_LIMIT_MID:   limit_ticks = MID_TICKS;
      `LFRSF_LIMIT_LONG:  limit_ticks = LONG_TICKS;
      `LFRSF_LIMIT_NONE:  limit_ticks = '0;
    endcase
  end

  // sync search timer; limit none never expires
  always_comb begin
    tmo_state_next = tmo_state_reg;
    tmo_cnt_next   = tmo_cnt_reg;
    shutdown_next  = shutdown_reg;
    unique case (tmo_state_reg)
      TMO_IDLE: begin
        if (ev_start && data_mode && limit_ticks != '0) begin // R1
          tmo_state_next = TMO_SEARCH;
          tmo_cnt_next   = '0;
        end
      end
      TMO_SEARCH: begin
        if (ev_sync || !data_mode || limit_ticks == '0) begin
          tmo_state_next = TMO_IDLE;
        end else if (osc_tick) begin // R2
          if (tmo_cnt_reg + 16'h0001 >= limit_ticks) begin
            tmo_state_next = TMO_EXPIRED;
            shutdown_next  = 1'b1;
          end else begin
            tmo_cnt_next = tmo_cnt_reg + 16'h0001;
          end
        end
      end
      TMO_EXPIRED: begin
        if (ev_start) begin
          tmo_state_next = (data_mode && limit_ticks != '0) ? TMO_SEARCH : TMO_IDLE;
          tmo_cnt_next   = '0;
          shutdown_next  = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      tmo_state_reg <= TMO_IDLE;
      tmo_cnt_reg   <= '0;
      shutdown_reg  <= 1'b0;
    end else begin
      tmo_state_reg <= tmo_state_next;
      tmo_cnt_reg   <= tmo_cnt_next;
      shutdown_reg  <= shutdown_next;
    end
  end

  assign RX_SHUTDOWN     = shutdown_reg;
  assign LOW_POWER_SNIFF = sniff_reg;
  assign LF_IRQ          = irq_reg;

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n);

  AST_BYTE_SETS_READY: assert property (byte_ev |=> dr_reg) // R4
    else $error("byte ready not set after byte");
  AST_READ_CLEARS: assert property (rd_data_clr && !byte_ev |=> !dr_reg) // R5
    else $error("byte ready not cleared by data read");
  AST_CARRIER_QUIET: assert property (!data_mode && !wr_ctrl |=> !er_reg && !ov_reg && !eom_reg) // R7
    else $error("data flags set in carrier mode");
  AST_TOGGLE_DIRECT: assert property (!data_mode && ctrl_reg.toggle_mode && ev_valid |=> cd_reg) // R9
    else $error("toggle mode validation did not set carrier flag");
  AST_OVERRUN: assert property (byte_ev && dr_reg && !rd_data_clr |=> ov_reg && dr_reg) // R11
    else $error("overrun not flagged");
  AST_ACK_CLEARS: assert property (ack_reg && !byte_ev && !ev_err && !ev_id && !ev_valid
                                   |=> !dr_reg && !er_reg && !id_reg && !ov_reg && !eom_reg) // R14
    else $error("ack left a flag set");
  AST_ACK_PULSE: assert property (wr_status && w_strb_reg[0] && w_data_reg[0] |=> ack_reg ##1 !ack_reg) // R15
    else $error("ack did not self clear");
  AST_SET_WINS: assert property (ack_reg && byte_ev |=> dr_reg) // R21
    else $error("set lost to ack");
  AST_PAGE_HIDES: assert property (rd_take && S_AXI_ARADDR[7:0] == `LFRSF_ADDR_STATUS
                                   && ctrl_reg.register_page_select |=> S_AXI_RDATA == 32'h0000_0000) // R18
    else $error("status visible with page set");
  AST_TIMEOUT: assert property (tmo_state_reg == TMO_SEARCH && osc_tick && !ev_sync && data_mode
                                && limit_ticks != '0 && tmo_cnt_reg + 16'h0001 >= limit_ticks
                                |=> RX_SHUTDOWN [*2]) // R2
    else $error("receiver not shut down at timeout");
  AST_IRQ_READY: assert property (dr_reg && ctrl_reg.byte_ready_irq_enable |=> LF_IRQ) // R4
    else $error("byte ready interrupt missing");
  AST_CD_IGNORED: assert property (data_mode && dec_on && !(dr_reg && ctrl_reg.byte_ready_irq_enable)
                                   && !(er_reg && ctrl_reg.receive_error_irq_enable)
                                   && !(id_reg && ctrl_reg.id_match_irq_enable) |=> !LF_IRQ) // R19
    else $error("carrier enable acted in data mode");

  COV_OVERRUN:  cover property (byte_ev ##[1:20] byte_ev && dr_reg);
  COV_TIMEOUT:  cover property ($rose(shutdown_reg));
  COV_ACK_RACE: cover property (ack_reg && byte_ev);

endmodule : lfrsf_top

/* File: test/lfrsf_lf_model.sv */
`timescale 1ns/1ps
module lfrsf_lf_model (
  input  wire logic             clock,   // bus clock
  output lfrsf_pkg::lfrsf_evt_s events,  // strobes and byte to the block
  output logic                  osc_clk  // receiver oscillator
);
  import lfrsf_pkg::*;
  // quiet link at start, oscillator stands still between bursts
  initial begin
    events = '0;
    osc_clk = 1'b0;
  end
  // byte settles 3 clocks ahead; strobe 2 high, 3 low so the sync sees both
  task automatic strobe(input logic [7:0] mask, input logic [7:0] data);
    events.rx_byte <= data;
    repeat (3) @(posedge clock);
    events[15:8] <= mask;
    repeat (2) @(posedge clock);
    events[15:8] <= 8'h00;
    events.rx_byte <= ~data; // stale byte must not look valid
    repeat (3) @(posedge clock);
  endtask : strobe
  // oscillator ticks at an eighth of the bus rate, the fastest allowed
  task automatic tick(input int n);
    repeat (n) begin
      osc_clk <= 1'b1;
      repeat (4) @(posedge clock);
      osc_clk <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask : tick
endmodule : lfrsf_lf_model

/* File: test/lfrsf_top_test.sv */
`timescale 1ns/1ps
module lfrsf_top_test;
  import lfrsf_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, osc, shut, sniff, irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [1:0] bresp, rresp;
  lfrsf_evt_s ev;
  int failures = 0, compares = 0;
  always #50 clk = ~clk;
  lfrsf_lf_model lf_u (.clock(clk), .events(ev), .osc_clk(osc));
  lfrsf_top dut_u (.CLOCK(clk), .RSTN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1), .LF_EVENTS(ev),
    .LF_OSC_CLK(osc), .RX_SHUTDOWN(shut), .LOW_POWER_SNIFF(sniff), .LF_IRQ(irq));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // readies are combinational on state, so they are settled at the falling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa | pw) begin
      @(negedge clk);
      pa = pa & ~awready;
      pw = pw & ~wready;
      @(posedge clk);
      awvalid <= pa;
      wvalid <= pw;
    end
    do @(negedge clk); while (!bvalid);
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge clk);
  endtask : rd
  task automatic stat(input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h24, d, r);
    chk("status", e, d);
  endtask : stat
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h20, d, r);
    chk("ctrl", 32'h0000_0008, d);
    stat(32'h0000_0002);
    chk("sniff", 1, sniff);
    rd(8'h30, d, r);
    chk("unmapped", 2'b10, r);
    wr(8'h30, 32'h0000_0000);
    chk("bresp", 2'b10, bresp);
    $display("reset test done");
  endtask : t_reset
  task automatic t_byte();
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h20, 32'h0000_0088);
    lf_u.strobe(8'h80, 8'h5A);
    stat(32'h0000_0082);
    chk("irq", 1, irq);
    lf_u.strobe(8'h80, 8'hA5);
    stat(32'h0000_008A);
    rd(8'h28, d, r);
    chk("data", 32'h0000_00A5, d);
    stat(32'h0000_000A);
    chk("irq", 0, irq);
    wr(8'h24, 32'h0000_0003);
    stat(32'h0000_0002);
    lf_u.strobe(8'h08, 8'h00);
    wr(8'h24, 32'h0000_0002);
    stat(32'h0000_0012);
    wr(8'h24, 32'h0000_0001);
    stat(32'h0000_0000);
    chk("sniff", 0, sniff);
    lf_u.strobe(8'hC4, 8'h33);
    stat(32'h0000_00C4);
    wr(8'h24, 32'h0000_0001);
    $display("byte test done");
  endtask : t_byte
  task automatic t_carrier();
    wr(8'h20, 32'h0000_1108);
    lf_u.strobe(8'h20, 8'h00);
    stat(32'h0000_0000);
    lf_u.strobe(8'h20, 8'h00);
    stat(32'h0000_0020);
    wr(8'h24, 32'h0000_0001);
    wr(8'h20, 32'h0000_F308);
    lf_u.strobe(8'hC4, 8'h11);
    stat(32'h0000_0000);
    lf_u.strobe(8'h20, 8'h00);
    stat(32'h0000_0020);
    wr(8'h20, 32'h0000_F328);
    stat(32'h0000_0020);
    chk("irq", 1, irq);
    wr(8'h20, 32'h0000_0428);
    stat(32'h0000_0000);
    chk("irq", 0, irq);
    wr(8'h24, 32'h0000_0003);
    wr(8'h20, 32'h0000_0008);
    stat(32'h0000_0020);
    $display("carrier test done");
  endtask : t_carrier
  task automatic t_timeout();
    wr(8'h20, 32'h0000_0009);
    lf_u.strobe(8'h01, 8'h00);
    lf_u.tick(7);
    chk("shutdown", 0, shut);
    lf_u.tick(1);
    chk("shutdown", 1, shut);
    lf_u.strobe(8'h01, 8'h00);
    chk("shutdown", 0, shut);
    wr(8'h20, 32'h0000_0008);
    lf_u.strobe(8'h01, 8'h00);
    lf_u.tick(9);
    chk("shutdown", 0, shut);
    $display("timeout test done");
  endtask : t_timeout
  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_byte();
    t_carrier();
    t_timeout();
    final_report();
  end
  // hang guard, around sixty times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule : lfrsf_top_test
